// *** include/pwrdn_defines.vh ***
// Purpose: constants for the shutdown and wake-up controller
// Assumes: registers on 32-bit words at byte offsets
// Notes:   included by the controller only; the bench uses literal values
`ifndef PWRDN_DEFINES_VH
`define PWRDN_DEFINES_VH

`define OFS_SHUTDOWN_COMMAND   4'h0
`define OFS_WAKE_CONFIGURATION 4'h4
`define OFS_WAKE_EVENT_FLAGS   4'h8
`define OFS_IRQ_MASK           4'hC

`define CMD_BIT                0
`define KEY_LSB                24
`define KEY_MSB                31
`define KEY_VALUE              8'hA5

`define EDGE_LSB               0
`define EDGE_MSB               1
`define DEB_LSB                4
`define DEB_MSB                7
`define ALARM_EN_BIT           17

`define FLAG_WAKE_BIT          0
`define FLAG_ALARM_BIT         17

`define CFG_RESET              32'h00000003
`define CFG_EDGE_RESET         2'h3
`define CFG_DEB_RESET          4'h0
`define FLAGS_RESET            32'h00000000
`define MASK_RESET             32'h00000000

`define EDGE_NONE              2'h0
`define EDGE_RISE              2'h1
`define EDGE_FALL              2'h2
`define EDGE_ANY               2'h3

`define DEB_MULT               16
`define CMD_DELAY              2

`endif

// *** verilog/shutdown_wakeup_controller.v ***
// Purpose: shutdown output control with debounced wake input and alarm wake
// Assumes: mclk is the always-running slow clock; rstn synchronous, active low
// Notes:   wake_input and rtc_alarm are asynchronous and pass three flops
`timescale 1ns/1ps
`include "pwrdn_defines.vh"

// Summary of operation
// - control write with command bit and key 0xA5 asserts shutdown output.
// - control write with wrong key is discarded with no effect.
// - edge select: 0 off, 1 rising, 2 falling, 3 any edge.
// - release after wake input holds level debounce*16+1 consecutive cycles.
// - with alarm wake enabled, an alarm deasserts the shutdown output.
// - with alarm wake disabled, the alarm is ignored completely.
// - wake input event sets status bit 0 until status is read.
// - alarm wake sets alarm status flag until status is next read.
// - whole controller clocked continuously by slow clock, no gating.
// - valid shutdown command reaches the output two cycles after the write.
// - new input change before debounce ends stops and clears the counter, except in any-edge mode, where it restarts the count.
// - alarm rising edge detected synchronously; software clears alarm first.
module shutdown_wakeup_controller #(
  parameter CNT_W = 9
) (
  input  wire        mclk,
  input  wire        rstn,
  input  wire [3:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  input  wire        wake_input,
  input  wire        rtc_alarm,
  output wire        power_down_output,
  output wire        irq
);

  localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
  localparam [CNT_W-1:0] CNT_ONE  = {{(CNT_W-1){1'b0}}, 1'b1};

  // single clock, no enable, every flop runs on every mclk edge
  reg  [1:0]       wake_edge_select_q;
  reg  [1:0]       wake_edge_select_d;
  reg  [3:0]       wake_debounce_count_q;
  reg  [3:0]       wake_debounce_count_d;
  reg              alarm_wake_enable_q;
  reg              alarm_wake_enable_d;
  reg              wake_input_seen_q;
  reg              wake_input_seen_d;
  reg              alarm_wake_seen_q;
  reg              alarm_wake_seen_d;
  reg  [1:0]       irq_mask_q;
  reg  [1:0]       irq_mask_d;
  reg              pd_q;
  reg              pd_d;
  reg              cmd_pend_q;
  reg              cmd_pend_d;
  reg  [2:0]       settle_q;
  reg  [2:0]       settle_d;
  reg              wk_level_q;
  reg              wk_level_d;
  reg              al_prev_q;
  reg              al_prev_d;
  reg              armed_q;
  reg              armed_d;
  reg              target_q;
  reg              target_d;
  reg  [CNT_W-1:0] cnt_q;
  reg  [CNT_W-1:0] cnt_d;
  reg              trig;

  // register decode
  wire cmd_sel  = wr && (addr == `OFS_SHUTDOWN_COMMAND);
  wire cfg_sel  = wr && (addr == `OFS_WAKE_CONFIGURATION);
  wire mask_sel = wr && (addr == `OFS_IRQ_MASK);
  wire flag_rd  = rd && (addr == `OFS_WAKE_EVENT_FLAGS);

  wire key_ok    = (wdata[`KEY_MSB:`KEY_LSB] == `KEY_VALUE);
  wire cmd_valid = cmd_sel && key_ok && wdata[`CMD_BIT];

  // pin synchronisers, bit 0 wake pin, bit 1 alarm
  wire [1:0] pin_raw = {rtc_alarm, wake_input};
  wire [1:0] pin_s2;
  wire [1:0] pin_s3;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      // first stage is read only by the second
      reg [2:0] stage_q;

      always @(posedge mclk) begin
        if (!rstn)
          stage_q <= 3'h0;
        else
          stage_q <= {stage_q[1:0], pin_raw[gi]};
      end

      assign pin_s2[gi] = stage_q[1];
      assign pin_s3[gi] = stage_q[2];
    end
  endgenerate

  // stages leave reset empty; the level trackers follow the pins
  // silently until the chain is full, so a pin idling high gives
  // no false edge after reset
  wire settled = settle_q[2];

  always @* begin
    settle_d = settle_q;
    if (!settled)
      settle_d = settle_q + 3'h1;
  end

  // filtered wake level: change counts once stages two and three agree
  wire wk_agree = (pin_s2[0] == pin_s3[0]);
  wire wk_new   = pin_s3[0];
  wire wk_chg   = settled && wk_agree && (wk_new != wk_level_q);
  wire al_level = pin_s3[1];
  wire al_rise  = settled && al_level && !al_prev_q;

  always @* begin
    wk_level_d = wk_level_q;
    if (!settled || wk_agree)
      wk_level_d = wk_new;
    al_prev_d = al_level;
  end

  always @* begin
    case (wake_edge_select_q)
      `EDGE_NONE: trig = 1'b0;
      `EDGE_RISE: trig = wk_chg && wk_new;
      `EDGE_FALL: trig = wk_chg && !wk_new;
      `EDGE_ANY:  trig = wk_chg;
      default:    trig = 1'b0;
    endcase
  end

  // hold length in cycles: debounce*16+1
  wire [CNT_W-1:0] hold_len =
    {wake_debounce_count_q, 4'h0} + CNT_ONE;
  wire [CNT_W-1:0] cnt_inc = cnt_q + CNT_ONE;
  wire wake_done  = armed_q && !wk_chg && (wk_level_q == target_q) &&
                    (cnt_inc >= hold_len);
  // zero debounce: the trigger cycle alone is the whole hold
  wire wake_now   = trig && (hold_len == CNT_ONE);
  wire wake_evt   = wake_done || wake_now;
  wire alarm_wake = alarm_wake_enable_q && al_rise;

  // debounce: counts cycles at the selected level after a trigger
  always @* begin
    armed_d  = armed_q;
    target_d = target_q;
    cnt_d    = cnt_q;
    if (trig) begin
      // the trigger cycle itself is the first cycle at the new level;
      // an opposite edge in any-edge mode restarts the count here
      armed_d  = !wake_now;
      target_d = wk_new;
      cnt_d    = CNT_ONE;
    end else if (wk_chg && armed_q) begin
      armed_d = 1'b0;
      cnt_d   = CNT_ZERO;
    end else if (wake_done) begin
      armed_d = 1'b0;
      cnt_d   = CNT_ZERO;
    end else if (armed_q) begin
      cnt_d = cnt_inc;
    end
  end

  // shutdown output: one pending stage, sticky until a wake
  always @* begin
    cmd_pend_d = cmd_valid;
    pd_d       = pd_q;
    // release wins over a command arriving in the same cycle
    if (wake_evt || alarm_wake)
      pd_d = 1'b0;
    else if (cmd_pend_q)
      pd_d = 1'b1;
  end

  assign power_down_output = pd_q;

  // configuration and mask; key-less command writes touch nothing
  always @* begin
    wake_edge_select_d    = wake_edge_select_q;
    wake_debounce_count_d = wake_debounce_count_q;
    alarm_wake_enable_d   = alarm_wake_enable_q;
    irq_mask_d            = irq_mask_q;
    if (cfg_sel) begin
      wake_edge_select_d    = wdata[`EDGE_MSB:`EDGE_LSB];
      wake_debounce_count_d = wdata[`DEB_MSB:`DEB_LSB];
      alarm_wake_enable_d   = wdata[`ALARM_EN_BIT];
    end
    if (mask_sel)
      irq_mask_d = {wdata[`FLAG_ALARM_BIT], wdata[`FLAG_WAKE_BIT]};
  end

  // sticky flags: a read clears, a same-cycle event wins
  always @* begin
    wake_input_seen_d = wake_input_seen_q;
    alarm_wake_seen_d = alarm_wake_seen_q;
    if (flag_rd) begin
      wake_input_seen_d = 1'b0;
      alarm_wake_seen_d = 1'b0;
    end
    // set after clear so an event in the read cycle is not lost
    if (wake_evt)
      wake_input_seen_d = 1'b1;
    if (alarm_wake)
      alarm_wake_seen_d = 1'b1;
  end

  // pin trackers and debounce state
  always @(posedge mclk) begin
    if (!rstn) begin
      settle_q   <= 3'h0;
      wk_level_q <= 1'b0;
      al_prev_q  <= 1'b0;
      armed_q    <= 1'b0;
      target_q   <= 1'b0;
      cnt_q      <= CNT_ZERO;
    end else begin
      settle_q   <= settle_d;
      wk_level_q <= wk_level_d;
      al_prev_q  <= al_prev_d;
      armed_q    <= armed_d;
      target_q   <= target_d;
      cnt_q      <= cnt_d;
    end
  end

  // shutdown output state
  always @(posedge mclk) begin
    if (!rstn) begin
      cmd_pend_q <= 1'b0;
      pd_q       <= 1'b0;
    end else begin
      cmd_pend_q <= cmd_pend_d;
      pd_q       <= pd_d;
    end
  end

  // software-visible registers
  always @(posedge mclk) begin
    if (!rstn) begin
      wake_edge_select_q    <= `CFG_EDGE_RESET;
      wake_debounce_count_q <= `CFG_DEB_RESET;
      alarm_wake_enable_q   <= 1'b0;
      irq_mask_q            <= 2'h0;
      wake_input_seen_q     <= 1'b0;
      alarm_wake_seen_q     <= 1'b0;
    end else begin
      wake_edge_select_q    <= wake_edge_select_d;
      wake_debounce_count_q <= wake_debounce_count_d;
      alarm_wake_enable_q   <= alarm_wake_enable_d;
      irq_mask_q            <= irq_mask_d;
      wake_input_seen_q     <= wake_input_seen_d;
      alarm_wake_seen_q     <= alarm_wake_seen_d;
    end
  end

  assign irq = (wake_input_seen_q && irq_mask_q[0]) ||
               (alarm_wake_seen_q && irq_mask_q[1]);

  // read data one cycle after the strobe, zero otherwise
  always @(posedge mclk) begin
    if (!rstn) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= 32'h00000000;
      if (rd) begin
        case (addr)
          `OFS_WAKE_CONFIGURATION: begin
            rdata[`EDGE_MSB:`EDGE_LSB] <= wake_edge_select_q;
            rdata[`DEB_MSB:`DEB_LSB]   <= wake_debounce_count_q;
            rdata[`ALARM_EN_BIT]       <= alarm_wake_enable_q;
          end
          `OFS_WAKE_EVENT_FLAGS: begin
            rdata[`FLAG_WAKE_BIT]  <= wake_input_seen_q;
            rdata[`FLAG_ALARM_BIT] <= alarm_wake_seen_q;
          end
          `OFS_IRQ_MASK: begin
            rdata[`FLAG_WAKE_BIT]  <= irq_mask_q[0];
            rdata[`FLAG_ALARM_BIT] <= irq_mask_q[1];
          end
          default: rdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// *** sim/pwrdn_sva.sv ***
// Purpose: port assertions for the shutdown controller
// Assumes: bench keeps the wake pin quiet around commands
// Notes:   cfg_q mirrors config writes
`timescale 1ns/1ps
module pwrdn_sva (
  input wire        mclk, rstn, wr, rd, wake_input, rtc_alarm,
  input wire        power_down_output, irq,
  input wire [3:0]  addr,
  input wire [31:0] wdata, rdata
);
  reg  [31:0] cfg_q;
  reg  [9:0]  run_q;
  reg         wk_q;
  wire        pd = power_down_output;
  wire [9:0]  need = {2'h0, cfg_q[7:4], 4'h0} + 10'h1;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  always @(posedge mclk) begin
    wk_q <= wake_input;
    // raw pin lead the filter, so this only bounds release from below
    run_q <= (wake_input != wk_q || !rstn) ? 10'h0 : run_q + {9'h0, ~&run_q};
    if (!rstn)
      cfg_q <= 32'h00000003;
    else if (wr && addr == 4'h4)
      cfg_q <= wdata;
  end
  sequence key_wr;
    wr && addr == 4'h0 && wdata[31:24] == 8'hA5;
  endsequence
  AST_CMD: assert property (key_wr ##0 wdata[0] && !pd |-> ##[2:3] pd)
    else $error("cmd lost");
  AST_KEY: assert property (
    wr && addr == 4'h0 && wdata[31:24] != 8'hA5 && !pd && !$past(wr) && !$past(wr, 2)
    |=> !pd[*3]) else $error("bad key used");
  AST_CFG: assert property (
    wr && addr == 4'h4 ##1 rd && addr == 4'h4 |=> rdata == ($past(wdata, 2) & 32'h000200F3))
    else $error("cfg readback");
  AST_RDQ: assert property (!$past(rd) |-> rdata == 32'h0) else $error("rdata idle");
  AST_FLG: assert property (rd && addr == 4'h8 |=> (rdata & 32'hFFFDFFFE) == 32'h0)
    else $error("flag bits");
  AST_AOFF: assert property (pd && !cfg_q[17] && $rose(rtc_alarm) |=> pd[*6])
    else $error("alarm not ignored");
  AST_AON: assert property (pd && cfg_q[17] && $rose(rtc_alarm) |-> ##[1:8] !pd)
    else $error("alarm no wake");
  AST_DEB: assert property (
    $fell(pd) && !cfg_q[17] |-> run_q >= need && cfg_q[1:0] != 2'h0)
    else $error("early release");
endmodule
bind shutdown_wakeup_controller pwrdn_sva u_pwrdn_sva (.mclk(mclk), .rstn(rstn), .wr(wr),
  .rd(rd), .wake_input(wake_input), .rtc_alarm(rtc_alarm), .irq(irq),
  .power_down_output(power_down_output), .addr(addr), .wdata(wdata), .rdata(rdata));

// *** sim/wake_pads.sv ***
// Purpose: wake button and alarm source at the pins
// Assumes: bench asks for levels; pins move just after an edge
// Notes:   alarm must drop between uses or no rise is seen
`timescale 1ns/1ps
module wake_pads (
  input  wire mclk, btn, alm,
  output reg  wake_input = 1'b0,
  output reg  rtc_alarm = 1'b0
);
  always @(posedge mclk) begin
    wake_input <= btn;
    rtc_alarm <= alm;
  end
endmodule

// *** sim/shutdown_wakeup_controller_tb_top.sv ***
// Purpose: self-checking bench for the shutdown controller
// Assumes: 20 MHz clock; stimulus by non-blocking assignment
// Notes:   debounce field 1 keeps wake waits short
`timescale 1ns/1ps
module shutdown_wakeup_controller_tb_top;
  logic        mclk = 0, rstn = 0, wr = 0, rd = 0, btn = 0, alm = 0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, q;
  wire  [31:0] rdata;
  wire         wake_input, rtc_alarm, pd, irq;
  integer      num_errors = 0, checks_done = 0, i;
  logic [67:0] rows [0:5] = '{68'h4FFFFFFFF000200F3, 68'h40000001200000012,
    68'h0A500000000000000, 68'hCFFFFFFFF00020001, 68'hEFFFFFFFF00000000,
    68'h8FFFFFFFF00000000};
  wake_pads u_wake_pads (.mclk(mclk), .btn(btn), .alm(alm), .wake_input(wake_input),
    .rtc_alarm(rtc_alarm));
  shutdown_wakeup_controller u_shutdown_wakeup_controller (.mclk(mclk), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .wake_input(wake_input),
    .rtc_alarm(rtc_alarm), .power_down_output(pd), .irq(irq));
  initial forever #25 mclk = ~mclk;
  task chk(input [31:0] s, input [31:0] e, input string n);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h saw %h", n, e, s);
    end
  endtask
  task wr_reg(input [3:0] a, input [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk) wr <= 1'b0;
  endtask
  task rd_reg(input [3:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk) rd <= 1'b0;
    #1 q = rdata;
    @(posedge mclk);
  endtask
  task wait_pd(input v);
    for (int k = 0; k < 60 && pd !== v; k++) @(posedge mclk);
    chk({31'h0, pd}, {31'h0, v}, "pin");
    if (pd !== v) tally_and_finish;
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    rd_reg(4'h4);
    chk(q, 32'h00000003, "cfg");
    rd_reg(4'h8);
    chk(q, 32'h0, "flags");
    chk({31'h0, pd}, 32'h0, "rstpin");
    chk({31'h0, irq}, 32'h0, "rstirq");
    $display("reset done");
    for (i = 0; i < 6; i++) begin
      wr_reg(rows[i][67:64], rows[i][63:32]);
      rd_reg(rows[i][67:64]);
      chk(q, rows[i][31:0], "row");
    end
    chk({31'h0, pd}, 32'h0, "nocmd");
    $display("rows done");
    wr_reg(4'h0, 32'h5A000001);
    repeat (5) @(posedge mclk);
    chk({31'h0, pd}, 32'h0, "badkey");
    wr_reg(4'h0, 32'hA5000001);
    wait_pd(1'b1);
    alm <= 1'b1;
    repeat (10) @(posedge mclk);
    chk({31'h0, pd}, 32'h1, "almoff");
    alm <= 1'b0;
    $display("command done");
    wr_reg(4'h4, 32'h00000011);
    btn <= 1'b1;
    repeat (8) @(posedge mclk);
    btn <= 1'b0;
    repeat (30) @(posedge mclk);
    chk({31'h0, pd}, 32'h1, "glitch");
    btn <= 1'b1;
    wait_pd(1'b0);
    chk({31'h0, irq}, 32'h1, "irq");
    rd_reg(4'h8);
    chk(q, 32'h00000001, "wake");
    rd_reg(4'h8);
    chk(q, 32'h0, "clear");
    chk({31'h0, irq}, 32'h0, "irqoff");
    $display("wake done");
    wr_reg(4'h4, 32'h00020000);
    rd_reg(4'h0);
    wr_reg(4'h0, 32'hA5000001);
    wait_pd(1'b1);
    btn <= 1'b0;
    repeat (30) @(posedge mclk);
    chk({31'h0, pd}, 32'h1, "mode0");
    alm <= 1'b1;
    wait_pd(1'b0);
    rd_reg(4'h8);
    chk(q, 32'h00020000, "alarm");
    $display("alarm done");
    tally_and_finish;
  end
endmodule
